// >>> tpo_defines.vh
// Purpose: constants of the timing pattern output block
// Assumes: register indices are printed offsets; byte address = 4 * index
// Notes: definitions only
`ifndef TPO_DEFINES_VH
`define TPO_DEFINES_VH

// register indices
`define TPO_IDX_MODE 16'hffa0
`define TPO_IDX_TRIG 16'hffa1
`define TPO_IDX_EN_HIGH 16'hffa2
`define TPO_IDX_EN_LOW 16'hffa3
`define TPO_IDX_NV_HIGH 16'hffa4
`define TPO_IDX_NV_LOW 16'hffa5
`define TPO_IDX_NV_G2 16'hffa6
`define TPO_IDX_NV_G0 16'hffa7
`define TPO_IDX_DIR_LOW 16'hffd1
`define TPO_IDX_VAL_LOW 16'hffd3
`define TPO_IDX_DIR_HIGH 16'hffd4
`define TPO_IDX_VAL_HIGH 16'hffd6

// reset values
`define TPO_RST_MODE 4'h0
`define TPO_RST_TRIG 8'hff
`define TPO_RST_BYTE 8'h00

// field layout
`define TPO_MODE_RSVD 4'hf
`define TPO_RSVD_NIB 4'hf
`define TPO_RSVD_BYTE 8'hff
`define TPO_TRIG_W 2
`define TPO_GRP_W 4
`define TPO_NGRP 4
`define TPO_PIN_MASK_HIGH 8'hbf

// bus answers
`define TPO_ADDR_W 18
`define TPO_RESP_OKAY 2'b00
`define TPO_RESP_SLVERR 2'b10

`endif

// >>> pattern_group.v
// Purpose: trigger detection and next data for one 4-bit output group
// Assumes: compare-match inputs are synchronous to aclk
// Notes: apply and data are combinational, valid in the edge cycle
`default_nettype none

module pattern_group #(
  parameter W = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire trig_a,
  input wire trig_b,
  input wire nonoverlap,
  input wire [W-1:0] cur,
  input wire [W-1:0] next_val,
  output reg apply,
  output reg [W-1:0] data
);

reg prev_a_r;
reg prev_b_r;
wire edge_a;
wire edge_b;

assign edge_a = trig_a & ~prev_a_r;
assign edge_b = trig_b & ~prev_b_r;

always @(posedge aclk) begin
  if (!aresetn) begin
    prev_a_r <= 1'b0;
    prev_b_r <= 1'b0;
  end else if (ce) begin
    prev_a_r <= trig_a;
    prev_b_r <= trig_b;
  end
end

// normal: load on match b; non-overlap: margin on a, load on b
always @* begin
  apply = 1'b0;
  data = next_val;
  if (edge_b) begin
    apply = ce;
  end else if (nonoverlap && edge_a) begin
    apply = ce;
    data = cur & next_val;
  end
end

endmodule // pattern_group
`default_nettype wire

// >>> timing_pattern_output.v
// Purpose: pulse pattern output unit with AXI4-Lite register access
// Assumes: compare-match inputs synchronous; one AXI write, one read at once
// Notes: ce low freezes every register, bus included
//
// Implementation choice: the AXI4-Lite interface to the registers.
`default_nettype none
`include "tpo_defines.vh"

// How it works
// - four 4-bit groups, each updating independently and concurrently.
// - output timing comes only from on-chip timer compare-match events.
// - fifteen pins; bit 14 exists inside but never reaches a pin.
// - each output bit has its own pattern enable.
// - each group selects its trigger among four timer channels.
// - four 4-bit trigger groups; group 3 still updates bit 14 internally.
// - non-overlap mode inserts a margin between successive pattern changes.
// - bits 0-3 group 0, 4-7 group 1, 8-11 group 2, 12-15 group 3.
// - CPU writes to pattern-enabled port value bits are ignored.
// - groups 0,1 on one trigger: whole next value low at one address.
// - groups 0,1 on two triggers: group 0 and group 1 split addresses.
// - groups 2,3 on one trigger: whole next value high at one address.
// - groups 2,3 on two triggers: group 2 and group 3 split addresses.
// - on trigger, enabled bits copy next data; others keep their value.
// - unused split next-data bits ignore writes and read as one.
module timing_pattern_output (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [3:0] cm_a,
  input wire [3:0] cm_b,
  input wire [`TPO_ADDR_W-1:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [`TPO_ADDR_W-1:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  output reg [7:0] pin_low_o,
  output reg [7:0] pin_low_oe,
  output reg [7:0] pin_high_o,
  output reg [7:0] pin_high_oe
);

function mapped;
  input [15:0] idx;
  begin
    case (idx)
      `TPO_IDX_MODE, `TPO_IDX_TRIG, `TPO_IDX_EN_HIGH,
      `TPO_IDX_EN_LOW, `TPO_IDX_NV_HIGH, `TPO_IDX_NV_LOW,
      `TPO_IDX_NV_G2, `TPO_IDX_NV_G0, `TPO_IDX_DIR_LOW,
      `TPO_IDX_VAL_LOW, `TPO_IDX_DIR_HIGH,
      `TPO_IDX_VAL_HIGH: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
endfunction

// register file
reg [3:0] nov_r;
reg [7:0] trig_r;
reg [7:0] en_high_r;
reg [7:0] en_low_r;
reg [7:0] nv_high_r;
reg [7:0] nv_low_r;
reg [7:0] dir_low_r;
reg [7:0] val_low_r;
reg [7:0] dir_high_r;
reg [7:0] val_high_r;
reg [3:0] nov_nxt;
reg [7:0] trig_nxt;
reg [7:0] en_high_nxt;
reg [7:0] en_low_nxt;
reg [7:0] nv_high_nxt;
reg [7:0] nv_low_nxt;
reg [7:0] dir_low_nxt;
reg [7:0] dir_high_nxt;
reg [15:0] val_nxt;

// bus state
reg aw_full_r;
reg w_full_r;
reg [15:0] aw_idx_r;
reg [7:0] wdata_r;
reg wstrb0_r;
reg [7:0] rd_byte;

wire do_wr;
wire wr_en;
wire [15:0] ar_idx;
wire same_low;
wire same_high;
wire [15:0] cur_all;
wire [15:0] nv_all;
wire [15:0] en_all;
wire [3:0] apply;
wire [15:0] grp_data;
wire [15:0] upd_mask;

assign do_wr = aw_full_r & w_full_r & ~bvalid;
assign wr_en = do_wr & wstrb0_r & mapped(aw_idx_r);
assign ar_idx = araddr[`TPO_ADDR_W-1:2];
assign same_low = trig_r[1:0] == trig_r[3:2];
assign same_high = trig_r[5:4] == trig_r[7:6];
assign cur_all = {val_high_r, val_low_r};
assign nv_all = {nv_high_r, nv_low_r};
assign en_all = {en_high_r, en_low_r};

// one trigger unit per group, each on its own selected channel
genvar g;
generate
  for (g = 0; g < `TPO_NGRP; g = g + 1) begin : grp
    pattern_group #(
      .W(`TPO_GRP_W)
    ) u_grp (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .trig_a(cm_a[trig_r[2*g +: `TPO_TRIG_W]]),
      .trig_b(cm_b[trig_r[2*g +: `TPO_TRIG_W]]),
      .nonoverlap(nov_r[g]),
      .cur(cur_all[4*g +: 4]),
      .next_val(nv_all[4*g +: 4]),
      .apply(apply[g]),
      .data(grp_data[4*g +: 4])
    );
    assign upd_mask[4*g +: 4] = {4{apply[g]}} & en_all[4*g +: 4];
  end
endgenerate

// next register values from cpu writes and group updates
always @* begin
  nov_nxt = nov_r;
  trig_nxt = trig_r;
  en_high_nxt = en_high_r;
  en_low_nxt = en_low_r;
  nv_high_nxt = nv_high_r;
  nv_low_nxt = nv_low_r;
  dir_low_nxt = dir_low_r;
  dir_high_nxt = dir_high_r;
  val_nxt = cur_all;
  if (wr_en) begin
    case (aw_idx_r)
      `TPO_IDX_MODE: nov_nxt = wdata_r[3:0];
      `TPO_IDX_TRIG: trig_nxt = wdata_r;
      `TPO_IDX_EN_HIGH: en_high_nxt = wdata_r;
      `TPO_IDX_EN_LOW: en_low_nxt = wdata_r;
      `TPO_IDX_NV_LOW: begin
        if (same_low) begin
          nv_low_nxt = wdata_r;
        end else begin
          nv_low_nxt[7:4] = wdata_r[7:4];
        end
      end
      `TPO_IDX_NV_G0: begin
        if (!same_low) begin
          nv_low_nxt[3:0] = wdata_r[3:0];
        end
      end
      `TPO_IDX_NV_HIGH: begin
        if (same_high) begin
          nv_high_nxt = wdata_r;
        end else begin
          nv_high_nxt[7:4] = wdata_r[7:4];
        end
      end
      `TPO_IDX_NV_G2: begin
        if (!same_high) begin
          nv_high_nxt[3:0] = wdata_r[3:0];
        end
      end
      `TPO_IDX_DIR_LOW: dir_low_nxt = wdata_r;
      `TPO_IDX_DIR_HIGH: dir_high_nxt = wdata_r;
      `TPO_IDX_VAL_LOW: begin
        val_nxt[7:0] = (val_low_r & en_low_r) |
          (wdata_r & ~en_low_r);
      end
      `TPO_IDX_VAL_HIGH: begin
        val_nxt[15:8] = (val_high_r & en_high_r) |
          (wdata_r & ~en_high_r);
      end
      default: begin
        nov_nxt = nov_r;
      end
    endcase
  end
  val_nxt = (val_nxt & ~upd_mask) | (grp_data & upd_mask);
end

// read data decode
always @* begin
  rd_byte = `TPO_RST_BYTE;
  case (ar_idx)
    `TPO_IDX_MODE: rd_byte = {`TPO_MODE_RSVD, nov_r};
    `TPO_IDX_TRIG: rd_byte = trig_r;
    `TPO_IDX_EN_HIGH: rd_byte = en_high_r;
    `TPO_IDX_EN_LOW: rd_byte = en_low_r;
    `TPO_IDX_NV_LOW: begin
      if (same_low) begin
        rd_byte = nv_low_r;
      end else begin
        rd_byte = {nv_low_r[7:4], `TPO_RSVD_NIB};
      end
    end
    `TPO_IDX_NV_G0: begin
      if (same_low) begin
        rd_byte = `TPO_RSVD_BYTE;
      end else begin
        rd_byte = {`TPO_RSVD_NIB, nv_low_r[3:0]};
      end
    end
    `TPO_IDX_NV_HIGH: begin
      if (same_high) begin
        rd_byte = nv_high_r;
      end else begin
        rd_byte = {nv_high_r[7:4], `TPO_RSVD_NIB};
      end
    end
    `TPO_IDX_NV_G2: begin
      if (same_high) begin
        rd_byte = `TPO_RSVD_BYTE;
      end else begin
        rd_byte = {`TPO_RSVD_NIB, nv_high_r[3:0]};
      end
    end
    `TPO_IDX_DIR_LOW: rd_byte = `TPO_RSVD_BYTE;
    `TPO_IDX_DIR_HIGH: rd_byte = `TPO_RSVD_BYTE;
    `TPO_IDX_VAL_LOW: rd_byte = val_low_r;
    `TPO_IDX_VAL_HIGH: rd_byte = val_high_r;
    default: rd_byte = `TPO_RST_BYTE;
  endcase
end

// registers and pins
always @(posedge aclk) begin
  if (!aresetn) begin
    nov_r <= `TPO_RST_MODE;
    trig_r <= `TPO_RST_TRIG;
    en_high_r <= `TPO_RST_BYTE;
    en_low_r <= `TPO_RST_BYTE;
    nv_high_r <= `TPO_RST_BYTE;
    nv_low_r <= `TPO_RST_BYTE;
    dir_low_r <= `TPO_RST_BYTE;
    dir_high_r <= `TPO_RST_BYTE;
    val_low_r <= `TPO_RST_BYTE;
    val_high_r <= `TPO_RST_BYTE;
    pin_low_o <= `TPO_RST_BYTE;
    pin_low_oe <= `TPO_RST_BYTE;
    pin_high_o <= `TPO_RST_BYTE;
    pin_high_oe <= `TPO_RST_BYTE;
  end else if (ce) begin
    nov_r <= nov_nxt;
    trig_r <= trig_nxt;
    en_high_r <= en_high_nxt;
    en_low_r <= en_low_nxt;
    nv_high_r <= nv_high_nxt;
    nv_low_r <= nv_low_nxt;
    dir_low_r <= dir_low_nxt;
    dir_high_r <= dir_high_nxt;
    val_low_r <= val_nxt[7:0];
    val_high_r <= val_nxt[15:8];
    pin_low_o <= val_nxt[7:0];
    pin_low_oe <= dir_low_nxt;
    pin_high_o <= val_nxt[15:8] & `TPO_PIN_MASK_HIGH;
    pin_high_oe <= dir_high_nxt & `TPO_PIN_MASK_HIGH;
  end
end

// axi4-lite write channel
always @(posedge aclk) begin
  if (!aresetn) begin
    awready <= 1'b0;
    wready <= 1'b0;
    aw_full_r <= 1'b0;
    w_full_r <= 1'b0;
    aw_idx_r <= 16'h0000;
    wdata_r <= `TPO_RST_BYTE;
    wstrb0_r <= 1'b0;
    bvalid <= 1'b0;
    bresp <= `TPO_RESP_OKAY;
  end else if (ce) begin
    if (awvalid && awready) begin
      aw_full_r <= 1'b1;
      aw_idx_r <= awaddr[`TPO_ADDR_W-1:2];
      awready <= 1'b0;
    end else if (!aw_full_r && !bvalid) begin
      awready <= 1'b1;
    end
    if (wvalid && wready) begin
      w_full_r <= 1'b1;
      wdata_r <= wdata[7:0];
      wstrb0_r <= wstrb[0];
      wready <= 1'b0;
    end else if (!w_full_r && !bvalid) begin
      wready <= 1'b1;
    end
    if (do_wr) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid <= 1'b1;
      bresp <= mapped(aw_idx_r) ? `TPO_RESP_OKAY : `TPO_RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end
end

// axi4-lite read channel
always @(posedge aclk) begin
  if (!aresetn) begin
    arready <= 1'b0;
    rvalid <= 1'b0;
    rdata <= 32'h0000_0000;
    rresp <= `TPO_RESP_OKAY;
  end else if (ce) begin
    if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_byte};
      rresp <= mapped(ar_idx) ? `TPO_RESP_OKAY : `TPO_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end
end

endmodule // timing_pattern_output
`default_nettype wire

// >>> tpo_chk.sv
// Purpose: port checks for timing_pattern_output
// Assumes: ce goes low only while the bus is idle
// Notes: bound into the design
`default_nettype none
`include "tpo_defines.vh"
module tpo_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] cm_a,
  input wire logic [3:0] cm_b,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [7:0] pin_low_o,
  input wire logic [7:0] pin_low_oe,
  input wire logic [7:0] pin_high_o,
  input wire logic [7:0] pin_high_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_w_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence ar_taken;
    arvalid && arready;
  endsequence
  wr_answer_a: assert property (aw_w_taken |-> ##2 bvalid)
    else $error("no write answer");
  rd_answer_a: assert property (ar_taken |=> rvalid)
    else $error("no read answer");
  b_stand_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  r_stand_a: assert property (rvalid && !rready |=>
    rvalid && $stable({rresp, rdata})) else $error("read answer dropped");
  wr_refuse_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answering");
  rd_refuse_a: assert property (rvalid |-> !arready)
    else $error("read taken while answering");
  rd_clean_a: assert property (rvalid |-> rdata[31:8] == 24'h0 &&
    (rresp != `TPO_RESP_SLVERR || rdata == 32'h0))
    else $error("bad read data");
  pin14_a: assert property (!pin_high_o[6] && !pin_high_oe[6])
    else $error("bit 14 reached a pin");
  pin_cause_a: assert property ($changed({pin_low_o, pin_high_o}) |->
    (|(($past(cm_a) & ~$past(cm_a, 2)) | ($past(cm_b) & ~$past(cm_b, 2))))
    || $rose(bvalid)) else $error("pins changed without cause");
  oe_cause_a: assert property ($changed({pin_low_oe, pin_high_oe}) |->
    $rose(bvalid)) else $error("direction changed without write");
endmodule // tpo_chk
bind timing_pattern_output tpo_chk u_chk (.aclk, .aresetn, .cm_a, .cm_b,
  .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid,
  .arready, .rdata, .rresp, .rvalid, .rready, .pin_low_o, .pin_low_oe,
  .pin_high_o, .pin_high_oe);
`default_nettype wire

// >>> cm_timer.sv
// Purpose: compare-match source standing in for the timer
// Assumes: pulses start just after a clock edge
// Notes: len sets a short or a long match pulse
`default_nettype none
module cm_timer (
  input wire logic aclk,
  output var logic [3:0] cm_a,
  output var logic [3:0] cm_b
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cm_a = 4'h0;
    cm_b = 4'h0;
  end
  task automatic fire(input int ch, input bit b, input int len);
    if (b) cm_b[ch] <= 1'b1;
    else cm_a[ch] <= 1'b1;
    repeat (len) @(posedge aclk);
    cm_a <= 4'h0;
    cm_b <= 4'h0;
    repeat (2) @(posedge aclk);
  endtask
endmodule // cm_timer
`default_nettype wire

// >>> tb_timing_pattern_output.sv
// Purpose: self-checking bench for timing_pattern_output
// Assumes: ce low only while the bus is idle; pulses from cm_timer
// Notes: bus answers queued and checked by a monitor
`default_nettype none
`include "tpo_defines.vh"
module tb_timing_pattern_output;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [3:0] cm_a, cm_b, wstrb = 4'hf;
  logic [17:0] awaddr = 18'h0, araddr = 18'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rnd = 32'h1825_f333;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] pin_low_o, pin_low_oe, pin_high_o, pin_high_oe;
  logic [33:0] eq[$];
  int bad_count = 0, n_tests = 0, cyc = 0;
  logic [15:0] ridx[12] = '{`TPO_IDX_MODE, `TPO_IDX_TRIG, `TPO_IDX_EN_HIGH,
    `TPO_IDX_EN_LOW, `TPO_IDX_NV_HIGH, `TPO_IDX_NV_LOW, `TPO_IDX_NV_G2,
    `TPO_IDX_NV_G0, `TPO_IDX_DIR_LOW, `TPO_IDX_VAL_LOW, `TPO_IDX_DIR_HIGH,
    `TPO_IDX_VAL_HIGH};
  logic [7:0] rexp[12] = '{8'hf0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
    8'hff, 8'hff, 8'h00, 8'hff, 8'h00};
  always #50 aclk = ~aclk;
  cm_timer u_tmr (.aclk, .cm_a, .cm_b);
  timing_pattern_output u_dut (.aclk, .aresetn, .ce, .cm_a, .cm_b, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .pin_low_o, .pin_low_oe, .pin_high_o, .pin_high_oe);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d,
      input logic [1:0] r = 2'b00);
    bit a, w;
    eq.push_back({r, 32'h0});
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    {awvalid, wvalid} <= 2'b11;
    a = 1;
    w = 1;
    while (a | w) begin
      @(posedge aclk);
      if (a && awready) begin a = 0; awvalid <= 1'b0; end
      if (w && wready) begin w = 0; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] d,
      input logic [1:0] r = 2'b00);
    eq.push_back({r, 24'h0, d});
    araddr <= {i, 2'b00};
    {arvalid, rready} <= 2'b11;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // monitor: answers against queued notes, plus run limit
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end else begin
      if (bvalid && bready) chk(eq.pop_front(), {bresp, 32'h0});
      if (rvalid && rready) chk(eq.pop_front(), {rresp, rdata});
    end
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (ridx[k]) rd(ridx[k], rexp[k]);
    rd(16'hffa8, 8'h00, `TPO_RESP_SLVERR);
    wr(16'hffa8, 8'h12, `TPO_RESP_SLVERR);
    repeat (3) begin
      rnd = lfsr(rnd);
      wr(`TPO_IDX_NV_LOW, rnd[7:0]);
      rd(`TPO_IDX_NV_LOW, rnd[7:0]);
    end
    wr(`TPO_IDX_DIR_LOW, 8'hff);
    wr(`TPO_IDX_EN_LOW, 8'h5a);
    wr(`TPO_IDX_NV_LOW, 8'hff);
    u_tmr.fire(3, 1, 1);
    rd(`TPO_IDX_VAL_LOW, 8'h5a);
    chk(34'h5aff, {18'h0, pin_low_o, pin_low_oe});
    wr(`TPO_IDX_NV_LOW, 8'h00);
    wr(`TPO_IDX_VAL_LOW, 8'ha5);
    rd(`TPO_IDX_VAL_LOW, 8'hff);
    u_tmr.fire(3, 1, 3);
    rd(`TPO_IDX_VAL_LOW, 8'ha5);
    wr(`TPO_IDX_TRIG, 8'he4);
    wr(`TPO_IDX_NV_LOW, 8'hc3);
    rd(`TPO_IDX_NV_LOW, 8'hcf);
    wr(`TPO_IDX_NV_G0, 8'h39);
    rd(`TPO_IDX_NV_G0, 8'hf9);
    wr(`TPO_IDX_EN_LOW, 8'hff);
    u_tmr.fire(0, 1, 1);
    rd(`TPO_IDX_VAL_LOW, 8'ha9);
    u_tmr.fire(1, 1, 2);
    rd(`TPO_IDX_VAL_LOW, 8'hc9);
    wr(`TPO_IDX_NV_HIGH, 8'h7e);
    rd(`TPO_IDX_NV_HIGH, 8'h7f);
    wr(`TPO_IDX_NV_G2, 8'h5b);
    rd(`TPO_IDX_NV_G2, 8'hfb);
    wr(`TPO_IDX_DIR_HIGH, 8'hff);
    wr(`TPO_IDX_EN_HIGH, 8'hff);
    u_tmr.fire(2, 1, 1);
    chk(34'h0bbf, {18'h0, pin_high_o, pin_high_oe});
    u_tmr.fire(3, 1, 1);
    chk(34'h3bbf, {18'h0, pin_high_o, pin_high_oe});
    wr(`TPO_IDX_MODE, 8'h01);
    rd(`TPO_IDX_MODE, 8'hf1);
    wr(`TPO_IDX_NV_G0, 8'h03);
    u_tmr.fire(0, 0, 1);
    rd(`TPO_IDX_VAL_LOW, 8'hc1);
    ce <= 1'b0;
    u_tmr.fire(0, 1, 1);
    ce <= 1'b1;
    rd(`TPO_IDX_VAL_LOW, 8'hc1);
    u_tmr.fire(0, 1, 1);
    rd(`TPO_IDX_VAL_LOW, 8'hc3);
    conclude();
  end
endmodule // tb_timing_pattern_output
`default_nettype wire
